// ==== rtl/sbil_defines.vh ====
/*
 * Constants for the strap boot image loader: reset timing, serial clock
 * ratios, image markers, CRC settings, source encodings.
 * Assumes a 125 MHz system clock and inclusion by bare name.
 */
`ifndef SBIL_DEFINES_VH
`define SBIL_DEFINES_VH

`define SBIL_CLK_PERIOD_NS 8
`define SBIL_RST_MIN_NS 15000
`define SBIL_RST_CYCLES ((`SBIL_RST_MIN_NS + `SBIL_CLK_PERIOD_NS - 1) / `SBIL_CLK_PERIOD_NS)

// Serial clock as a division of the core clock (15.625 MHz and 781.25 kHz of 125 MHz)
`define SBIL_QSPI_RATIO 8
`define SBIL_SPI_RATIO 160

`define SBIL_SECURE_BIT 5
`define SBIL_READ_CMD 8'h03
`define SBIL_NO_CRC 32'h0d15ab1e
`define SBIL_CRC_POLY 32'hedb88320
`define SBIL_CRC_INIT 32'hffffffff
`define SBIL_NULL_CHAN 32'h0000ff02

// One-hot boot source codes
`define SBIL_SRC_QSPI 5'h01
`define SBIL_SRC_SPIM 5'h02
`define SBIL_SRC_SPIS 5'h04
`define SBIL_SRC_CHAN 5'h08
`define SBIL_SRC_OTP 5'h10

// Link enable masks, bit n = link n
`define SBIL_LINKS_ZERO 8'h01
`define SBIL_LINKS_UPPER 8'hf0
`define SBIL_LINKS_MIXED 8'h66
`define SBIL_LINKS_LOWER 8'h0f

`endif

// ==== rtl/sbil_loader.v ====
/*
 * Boot sequencer and image loader for tile 0, plus boot source decode for
 * both tiles. Holds reset, times the internal reset, latches straps, runs a
 * serial flash master, SPI slave, link or OTP byte source, parses the image,
 * writes RAM and checks the CRC.
 * Assumes all inputs are synchronous to clk_i and that RAM takes one write
 * per cycle; link and OTP byte transport live outside this block.
 */
`include "sbil_defines.vh"
`default_nettype none

// Function
// [RULE1] Hold reset and pull-downs while chip reset low
// [RULE2] Internal reset delay before boot starts
// [RULE3] Secure bit forces boot from OTP
// [RULE4] Strap high bit zero: no links, tile0 by code
// [RULE5] Strap high bit one: channel boot, links by code
// [RULE6] Image is length, program words, CRC word
// [RULE7] Magic trailing word skips CRC check
// [RULE8] Length and CRC assembled low byte first
// [RULE9] Load from lowest RAM address, run there
// [RULE10] CRC covers length and program bytes only
// [RULE11] Reflected CRC, preset all ones, result inverted
// [RULE12] Quad flash master: read at zero, low nibble first
// [RULE13] Single flash master: read at zero, LSB first
// [RULE14] SPI slave modes 0/0 and 1/1, LSB first
// [RULE15] Link: ack channel, image, end token, reply
// [RULE16] Straps sampled once, held until chip reset
module sbil_loader #(
   parameter ADDR_W = 17
) (
   input wire clk_i,
   input wire rstn_i,
   input wire boot_strap_bit0_i,
   input wire boot_strap_bit1_i,
   input wire boot_strap_bit2_i,
   input wire [15:0] sec0_reg_i,
   input wire [15:0] sec1_reg_i,
   input wire [3:0] dq_i,
   input wire slv_sclk_i,
   input wire slv_ss_n_i,
   input wire link_rx_vld_i,
   input wire [7:0] link_rx_byte_i,
   input wire link_rx_end_i,
   input wire [7:0] otp_byte_i,
   output reg pulldown_en_o,
   output reg core_rst_n_o,
   output reg [4:0] tile0_src_o,
   output reg [4:0] tile1_src_o,
   output reg [7:0] link_en_o,
   output reg link_5w_o,
   output reg spi_sclk_o,
   output reg spi_ss_n_o,
   output reg [3:0] dq_o,
   output reg [3:0] dq_oe_o,
   output reg link_tx_end_o,
   output reg [31:0] link_tx_chan_o,
   output reg otp_rd_o,
   output reg [ADDR_W-1:0] otp_addr_o,
   output reg ram_we_o,
   output reg [ADDR_W-1:0] ram_addr_o,
   output reg [31:0] ram_wdata_o,
   output reg run_o,
   output reg [ADDR_W-1:0] run_addr_o,
   output reg fail_o
);

   localparam [7:0] S_IRST = 8'h01;
   localparam [7:0] S_ACK = 8'h02;
   localparam [7:0] S_LEN = 8'h04;
   localparam [7:0] S_PROG = 8'h08;
   localparam [7:0] S_CRC = 8'h10;
   localparam [7:0] S_END = 8'h20;
   localparam [7:0] S_RUN = 8'h40;
   localparam [7:0] S_FAIL = 8'h80;
   localparam integer RST_INT = `SBIL_RST_CYCLES;
   localparam integer QHALF_INT = `SBIL_QSPI_RATIO / 2;
   localparam integer SHALF_INT = `SBIL_SPI_RATIO / 2;
   localparam [11:0] RST_CNT = RST_INT[11:0];
   localparam [7:0] QHALF = QHALF_INT[7:0];
   localparam [7:0] SHALF = SHALF_INT[7:0];

   // ---------------------------------------------------------------
   // CRC byte step
   // ---------------------------------------------------------------
   function [31:0] crc_byte;
      input [31:0] c;
      input [7:0] d;
      integer i;
      reg [31:0] r;
      begin
         r = c ^ {24'h000000, d};
         for (i = 0; i < 8; i = i + 1) begin
            r = r[0] ? ((r >> 1) ^ `SBIL_CRC_POLY) : (r >> 1); // RULE11
         end
         crc_byte = r;
      end
   endfunction

   reg [7:0] state;
   reg [11:0] rst_cnt;
   reg [31:0] word;
   reg [1:0] bcnt;
   reg [31:0] remain;
   reg [31:0] crc;
   reg [ADDR_W-1:0] waddr;

   // Serial engine state
   reg [7:0] div_cnt;
   reg [31:0] cmd_sh;
   reg [5:0] cmd_cnt;
   reg [7:0] rx_sh;
   reg [2:0] rx_cnt;
   reg sclk_d;
   reg otp_pend;

   wire loading = state[1] | state[2] | state[3] | state[4];
   wire [7:0] half = tile0_src_o[0] ? QHALF : SHALF;
   wire master = tile0_src_o[0] | tile0_src_o[1];
   wire edge_now = master & loading & (div_cnt == half - 8'h01);
   wire rise = edge_now & ~spi_sclk_o;
   wire fall = edge_now & spi_sclk_o;
   wire slv_rise = tile0_src_o[2] & ~slv_ss_n_i & slv_sclk_i & ~sclk_d;
   wire [2:0] rx_step = tile0_src_o[0] ? 3'h4 : 3'h1;
   wire [7:0] rx_next = tile0_src_o[0] ? {dq_i, rx_sh[7:4]} : {dq_i[1], rx_sh[7:1]};
   wire [7:0] slv_next = {dq_i[0], rx_sh[7:1]};

   // ---------------------------------------------------------------
   // Byte source mux
   // ---------------------------------------------------------------
   reg byte_vld;
   reg [7:0] byte_dat;
   always @* begin
      byte_vld = 1'b0;
      byte_dat = 8'h00;
      case (tile0_src_o)
         `SBIL_SRC_QSPI, `SBIL_SRC_SPIM: begin
            byte_vld = rise && (cmd_cnt == 6'd32) && (rx_cnt + rx_step == 3'h0); // RULE12 RULE13
            byte_dat = rx_next;
         end
         `SBIL_SRC_SPIS: begin
            byte_vld = slv_rise && (rx_cnt == 3'h7); // RULE14
            byte_dat = slv_next;
         end
         `SBIL_SRC_CHAN: begin
            byte_vld = link_rx_vld_i;
            byte_dat = link_rx_byte_i;
         end
         `SBIL_SRC_OTP: begin
            byte_vld = otp_pend;
            byte_dat = otp_byte_i;
         end
         default: begin
            byte_vld = 1'b0;
         end
      endcase
   end

   wire [31:0] word_next = {byte_dat, word[31:8]}; // RULE8
   wire word_done = byte_vld && (bcnt == 2'h3);

   // ---------------------------------------------------------------
   // Reset, strap decode and image parser
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= S_IRST;
         rst_cnt <= 12'h000;
         pulldown_en_o <= 1'b1; // RULE1
         core_rst_n_o <= 1'b0; // RULE1
         tile0_src_o <= 5'h00;
         tile1_src_o <= 5'h00;
         link_en_o <= 8'h00;
         link_5w_o <= 1'b0;
         word <= 32'h00000000;
         bcnt <= 2'h0;
         remain <= 32'h00000000;
         crc <= `SBIL_CRC_INIT;
         waddr <= {ADDR_W{1'b0}};
         ram_we_o <= 1'b0;
         ram_addr_o <= {ADDR_W{1'b0}};
         ram_wdata_o <= 32'h00000000;
         link_tx_end_o <= 1'b0;
         link_tx_chan_o <= 32'h00000000;
         run_o <= 1'b0;
         run_addr_o <= {ADDR_W{1'b0}};
         fail_o <= 1'b0;
      end else begin
         ram_we_o <= 1'b0;
         link_tx_end_o <= 1'b0;
         pulldown_en_o <= 1'b0;
         if (byte_vld && loading) begin
            word <= word_next;
            bcnt <= bcnt + 2'h1;
         end
         case (state)
            S_IRST: begin
               rst_cnt <= rst_cnt + 12'h001; // RULE2
               if (rst_cnt == RST_CNT - 12'h001) begin
                  // Straps latched here only; later pin changes are ignored
                  state <= S_LEN; // RULE16
                  link_5w_o <= boot_strap_bit2_i & (boot_strap_bit1_i | boot_strap_bit0_i);
                  tile1_src_o <= sec1_reg_i[`SBIL_SECURE_BIT] ? `SBIL_SRC_OTP :
                     ({boot_strap_bit2_i, boot_strap_bit1_i, boot_strap_bit0_i} == 3'h3) ?
                     `SBIL_SRC_SPIS : `SBIL_SRC_CHAN; // RULE3 RULE4
                  if (!boot_strap_bit2_i) begin
                     link_en_o <= 8'h00; // RULE4
                     case ({boot_strap_bit1_i, boot_strap_bit0_i})
                        2'h0: tile0_src_o <= `SBIL_SRC_QSPI;
                        2'h1: tile0_src_o <= `SBIL_SRC_SPIM;
                        default: tile0_src_o <= `SBIL_SRC_SPIS;
                     endcase
                  end else begin
                     tile0_src_o <= `SBIL_SRC_CHAN; // RULE5
                     state <= S_ACK;
                     case ({boot_strap_bit1_i, boot_strap_bit0_i})
                        2'h0: link_en_o <= `SBIL_LINKS_ZERO;
                        2'h1: link_en_o <= `SBIL_LINKS_UPPER;
                        2'h2: link_en_o <= `SBIL_LINKS_MIXED;
                        default: link_en_o <= `SBIL_LINKS_LOWER;
                     endcase
                  end
                  if (sec0_reg_i[`SBIL_SECURE_BIT]) begin
                     tile0_src_o <= `SBIL_SRC_OTP; // RULE3
                     state <= S_LEN;
                  end
               end
            end
            S_ACK: if (word_done) begin
               link_tx_chan_o <= word_next; // RULE15
               state <= S_LEN;
            end
            S_LEN: if (byte_vld) begin
               crc <= crc_byte(crc, byte_dat); // RULE10
               if (word_done) begin
                  remain <= word_next; // RULE6
                  state <= (word_next == 32'h00000000) ? S_CRC : S_PROG;
               end
            end
            S_PROG: if (byte_vld) begin
               crc <= crc_byte(crc, byte_dat); // RULE10
               if (word_done) begin
                  ram_we_o <= 1'b1;
                  ram_addr_o <= waddr; // RULE9
                  ram_wdata_o <= word_next;
                  waddr <= waddr + {{(ADDR_W-1){1'b0}}, 1'b1};
                  remain <= remain - 32'h00000001;
                  if (remain == 32'h00000001) begin
                     state <= S_CRC; // RULE6
                  end
               end
            end
            S_CRC: if (word_done) begin
               if (word_next == `SBIL_NO_CRC || word_next == ~crc) begin // RULE7 RULE11
                  state <= tile0_src_o[3] ? S_END : S_RUN;
               end else begin
                  state <= S_FAIL;
               end
            end
            S_END: if (link_rx_end_i) begin
               link_tx_end_o <= (link_tx_chan_o != `SBIL_NULL_CHAN); // RULE15
               state <= S_RUN;
            end
            S_RUN: begin
               core_rst_n_o <= 1'b1;
               run_o <= 1'b1;
               run_addr_o <= {ADDR_W{1'b0}}; // RULE9
            end
            S_FAIL: fail_o <= 1'b1;
            default: state <= S_FAIL;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Flash master, SPI slave shifter and OTP reader
   // ---------------------------------------------------------------
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_cnt <= 8'h00;
         spi_sclk_o <= 1'b0;
         spi_ss_n_o <= 1'b1;
         dq_o <= 4'h0;
         dq_oe_o <= 4'h0;
         cmd_sh <= {`SBIL_READ_CMD, 24'h000000};
         cmd_cnt <= 6'd0;
         rx_sh <= 8'h00;
         rx_cnt <= 3'h0;
         // High after reset so an idle-high host clock gives no false edge
         sclk_d <= 1'b1;
         otp_pend <= 1'b0;
         otp_rd_o <= 1'b0;
         otp_addr_o <= {ADDR_W{1'b0}};
      end else begin
         sclk_d <= slv_sclk_i;
         if (master && loading) begin
            // Command goes out MSB first on one line, mode 0: shift on fall
            spi_ss_n_o <= 1'b0;
            dq_oe_o <= (cmd_cnt == 6'd32) ? 4'h0 : 4'h1;
            dq_o <= {3'h0, cmd_sh[31]}; // RULE12 RULE13
            div_cnt <= edge_now ? 8'h00 : div_cnt + 8'h01;
            if (edge_now) begin
               spi_sclk_o <= ~spi_sclk_o;
            end
            if (fall && cmd_cnt != 6'd32) begin
               cmd_sh <= {cmd_sh[30:0], 1'b0};
            end
            if (rise) begin
               if (cmd_cnt != 6'd32) begin
                  cmd_cnt <= cmd_cnt + 6'd1;
               end else begin
                  rx_sh <= rx_next;
                  rx_cnt <= rx_cnt + rx_step;
               end
            end
         end else begin
            spi_ss_n_o <= 1'b1;
            spi_sclk_o <= 1'b0;
            dq_oe_o <= 4'h0;
            div_cnt <= 8'h00;
         end
         if (tile0_src_o[2]) begin
            // Slave framing restarts whenever select is released
            if (slv_ss_n_i) begin
               rx_cnt <= 3'h0;
            end else if (slv_rise) begin
               rx_sh <= slv_next; // RULE14
               rx_cnt <= rx_cnt + 3'h1;
            end
         end
         // OTP read: one request, data back on the next cycle
         otp_pend <= otp_rd_o;
         otp_rd_o <= tile0_src_o[4] && loading && !otp_rd_o && !otp_pend; // RULE3
         if (otp_rd_o) begin
            otp_addr_o <= otp_addr_o + {{(ADDR_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // sbil_loader

`default_nettype wire

// ==== bench/sbil_flash_model.sv ====
/* Quad serial flash at the loader's master pins, serving the bench image.
   Assumes mode 0/0 and that the bench resolves the shared data lines. */
`include "sbil_defines.vh"
`default_nettype none
module sbil_flash_model (
   input wire logic spi_sclk_i,
   input wire logic spi_ss_n_i,
   input wire logic cmd_i,
   input var logic [7:0] img_i [0:63],
   output logic [3:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int rises = 0;
   int nib = 0;
   logic [31:0] cmd = 32'h0;
   initial dq_o = 4'h0;
   always @(negedge spi_ss_n_i) begin
      rises = 0;
      nib = 0;
   end
   always @(posedge spi_sclk_i) begin
      if (!spi_ss_n_i && rises < 32) cmd = {cmd[30:0], cmd_i};
      rises = rises + 1;
   end
   // Released or wrongly addressed: toggle, so a stale value never reads right
   always @(negedge spi_sclk_i or posedge spi_ss_n_i) begin
      if (!spi_ss_n_i && rises >= 32 && cmd == {`SBIL_READ_CMD, 24'h0}) begin
         dq_o <= nib[0] ? img_i[nib/2][7:4] : img_i[nib/2][3:0];
         nib = nib + 1;
      end else if (spi_ss_n_i || rises >= 32)
         dq_o <= ~dq_o;
   end
endmodule // sbil_flash_model
`default_nettype wire

// ==== bench/sbil_loader_chk.sv ====
/* Port checker for the loader: reset hold, source latch, RAM order, replies.
   Assumes one clock and image bytes no faster than one a cycle. */
`include "sbil_defines.vh"
`default_nettype none
module sbil_loader_chk #(
   parameter ADDR_W = 17
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic boot_strap_bit2_i,
   input wire logic [15:0] sec0_reg_i,
   input wire logic link_rx_end_i,
   input wire logic pulldown_en_o,
   input wire logic core_rst_n_o,
   input wire logic [4:0] tile0_src_o,
   input wire logic [4:0] tile1_src_o,
   input wire logic [7:0] link_en_o,
   input wire logic link_5w_o,
   input wire logic spi_ss_n_o,
   input wire logic [3:0] dq_oe_o,
   input wire logic link_tx_end_o,
   input wire logic [31:0] link_tx_chan_o,
   input wire logic ram_we_o,
   input wire logic [ADDR_W-1:0] ram_addr_o,
   input wire logic run_o,
   input wire logic [ADDR_W-1:0] run_addr_o,
   input wire logic fail_o
);
   localparam int RC = `SBIL_RST_CYCLES;
   logic [10:0] cnt;
   logic [ADDR_W-1:0] wcnt;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // Cycles since release, saturating well past the latch point
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i) cnt <= '0;
      else if (cnt != '1) cnt <= cnt + 1'b1;
   always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i) wcnt <= '0;
      else if (ram_we_o) wcnt <= wcnt + 1'b1;
   chk_pulldown_rel: assert property (pulldown_en_o == (cnt == 11'h000))
      else $error("pull-down not tied to reset");
   chk_boot_wait: assert property ((cnt < RC) |-> tile0_src_o == 5'h00 && !core_rst_n_o)
      else $error("boot began early");
   chk_boot_start: assert property ((cnt == RC) |-> $onehot(tile0_src_o) && $onehot(tile1_src_o))
      else $error("boot source not latched in time");
   chk_src_held: assert property ((cnt > RC) |->
      $stable({tile0_src_o, tile1_src_o, link_en_o, link_5w_o}))
      else $error("boot selection moved");
   chk_secure_otp: assert property ((cnt >= RC && sec0_reg_i[5]) |->
      tile0_src_o == `SBIL_SRC_OTP)
      else $error("secure boot ignored");
   chk_strap_nolink: assert property ((cnt >= RC && !boot_strap_bit2_i) |->
      link_en_o == 8'h00 && !link_5w_o)
      else $error("links enabled wrongly");
   chk_strap_chan: assert property ((cnt >= RC && boot_strap_bit2_i && !sec0_reg_i[5]) |->
      tile0_src_o == `SBIL_SRC_CHAN && link_en_o != 8'h00)
      else $error("channel boot not chosen");
   chk_ram_order: assert property (ram_we_o |-> ram_addr_o == wcnt ##1 !ram_we_o [*3])
      else $error("RAM write out of order");
   chk_run_zero: assert property (run_o |-> run_addr_o == '0 && core_rst_n_o && !fail_o)
      else $error("bad start of execution");
   chk_fail_held: assert property (fail_o |=> fail_o && !run_o)
      else $error("failure not held");
   chk_flash_idle: assert property (!(tile0_src_o inside {`SBIL_SRC_QSPI, `SBIL_SRC_SPIM}) |->
      spi_ss_n_o && dq_oe_o == 4'h0)
      else $error("flash pins active");
   chk_link_reply: assert property (link_tx_end_o |-> ($past(link_rx_end_i) ||
      $past(link_rx_end_i, 2)) && link_tx_chan_o != `SBIL_NULL_CHAN ##1 !link_tx_end_o)
      else $error("bad end token reply");
   cover property ($rose(run_o));
   cover property ($rose(fail_o));
   cover property (link_tx_end_o);
   cover property (ram_we_o ##4 ram_we_o);
endmodule // sbil_loader_chk
bind sbil_loader sbil_loader_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ==== bench/testbench.sv ====
/* Bench for the loader: strap decode, quad flash, link and OTP boots.
   Assumes the flash model on the master pins; link and OTP bytes come from here. */
`include "sbil_defines.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0;
   logic rstn_i = 0;
   logic boot_strap_bit0_i = 0, boot_strap_bit1_i = 0, boot_strap_bit2_i = 0;
   logic [15:0] sec0_reg_i = 0, sec1_reg_i = 0;
   logic slv_sclk_i = 0, slv_ss_n_i = 1, link_rx_vld_i = 0, link_rx_end_i = 0;
   logic [7:0] link_rx_byte_i = 0, otp_byte_i = 0, link_en_o;
   logic [3:0] dq_i, dq_o, dq_oe_o, fq;
   logic [4:0] tile0_src_o, tile1_src_o;
   logic pulldown_en_o, core_rst_n_o, link_5w_o, spi_sclk_o, spi_ss_n_o, link_tx_end_o;
   logic otp_rd_o, ram_we_o, run_o, fail_o;
   logic [31:0] link_tx_chan_o, ram_wdata_o;
   logic [16:0] otp_addr_o, ram_addr_o, run_addr_o;
   logic [7:0] img [0:63];
   logic [31:0] exp_q [$];
   int n_img, widx, ends, errors = 0, comparisons = 0;
   sbil_loader dut (.*);
   sbil_flash_model fm (.spi_sclk_i(spi_sclk_o), .spi_ss_n_i(spi_ss_n_o), .cmd_i(dq_i[0]),
      .img_i(img), .dq_o(fq));
   // Shared data lines: the device wins where it enables its driver
   assign dq_i = (dq_oe_o & dq_o) | (~dq_oe_o & fq);
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) otp_byte_i <= (otp_rd_o === 1'b1) ? img[otp_addr_o[5:0]] : ~otp_byte_i;
   always @(posedge clk_i) if (link_tx_end_o === 1'b1) ends <= ends + 1;
   always @(posedge clk_i) if (ram_we_o === 1'b1) begin
      check(ram_addr_o, widx);
      check(ram_wdata_o, exp_q[widx]);
      widx <= widx + 1;
   end
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [31:0] crc_of(int n);
      logic [31:0] c;
      c = `SBIL_CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = c ^ img[i];
         for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ `SBIL_CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction
   // Kind 0 good CRC, 1 no-check marker, 2 corrupted CRC
   task automatic build(int len, int kind);
      logic [31:0] w;
      exp_q.delete();
      n_img = 8 + 4 * len;
      for (int i = 0; i < 4; i++) img[i] = 8'(len >> (8 * i));
      for (int k = 0; k < len; k++) begin
         w = $urandom;
         exp_q.push_back(w);
         for (int i = 0; i < 4; i++) img[4 + 4 * k + i] = w[8 * i +: 8];
      end
      w = kind == 1 ? `SBIL_NO_CRC : crc_of(4 + 4 * len) ^ 32'(kind == 2);
      for (int i = 0; i < 4; i++) img[4 + 4 * len + i] = w[8 * i +: 8];
   endtask
   task automatic boot(logic [2:0] s, logic [15:0] a, logic [15:0] b);
      logic [7:0] lk;
      @(posedge clk_i);
      rstn_i <= 0;
      {boot_strap_bit2_i, boot_strap_bit1_i, boot_strap_bit0_i} <= s;
      sec0_reg_i <= a;
      sec1_reg_i <= b;
      repeat (20) @(posedge clk_i);
      check({pulldown_en_o, core_rst_n_o}, 2'b10);
      rstn_i <= 1;
      widx = 0;
      ends = 0;
      repeat (`SBIL_RST_CYCLES + 2) @(posedge clk_i);
      #1;
      case (s[1:0])
         0: lk = `SBIL_LINKS_ZERO;
         1: lk = `SBIL_LINKS_UPPER;
         2: lk = `SBIL_LINKS_MIXED;
         default: lk = `SBIL_LINKS_LOWER;
      endcase
      check(tile0_src_o, a[5] ? `SBIL_SRC_OTP : s[2] ? `SBIL_SRC_CHAN : s[1] ? `SBIL_SRC_SPIS
         : s[0] ? `SBIL_SRC_SPIM : `SBIL_SRC_QSPI);
      check(tile1_src_o, b[5] ? `SBIL_SRC_OTP : s == 3 ? `SBIL_SRC_SPIS : `SBIL_SRC_CHAN);
      check({link_en_o, link_5w_o}, s[2] ? {lk, s[1:0] != 0} : 9'h000);
      check(pulldown_en_o, 0);
      @(posedge clk_i);
   endtask
   task automatic wait_done();
      int k;
      k = 0;
      while (run_o !== 1'b1 && fail_o !== 1'b1 && k < 20000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 20000) begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic send(logic [31:0] w, int n);
      for (int i = 0; i < n; i++) begin
         repeat (1 + $urandom_range(2)) @(posedge clk_i);
         link_rx_byte_i <= w[8 * i +: 8];
         link_rx_vld_i <= 1;
         @(posedge clk_i);
         link_rx_vld_i <= 0;
      end
   endtask
   initial begin
      void'($urandom(32'hf374));
      build(5, 0);
      for (int s = 0; s < 8; s++) begin
         boot(3'(s), 16'h0000, 16'h0000);
         if (s == 0) begin
            wait_done();
            check({run_o, core_rst_n_o, fail_o}, 3'b110);
            check(widx, 5);
            check(spi_ss_n_o, 1);
         end
      end
      for (int c = 0; c < 2; c++) begin
         boot(3'b100, 16'h0000, 16'h0000);
         build(2, 1);
         send(c ? `SBIL_NULL_CHAN : 32'h00010203, 4);
         for (int i = 0; i < n_img; i++) send(img[i], 1);
         link_rx_end_i <= 1;
         @(posedge clk_i);
         link_rx_end_i <= 0;
         wait_done();
         repeat (3) @(posedge clk_i);
         check({run_o, fail_o}, 2'b10);
         check(ends, c ? 0 : 1);
         check(widx, 2);
      end
      build(0, 2);
      boot(3'b101, 16'h0020, 16'h0020);
      wait_done();
      check({run_o, core_rst_n_o, fail_o}, 3'b001);
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
